// ===== isd_pkg.sv
// constants and types shared by the isolated switch driver control logic
package isd_pkg;

   // clock period of the control logic, in ns
   localparam int CLOCK_PERIOD_NS = 25;

   // one-shot gate pulse width, fixed inside the device
   localparam int ONE_SHOT_WIDTH_NS = 1000;

   // hold-over time before the driver is forced off after primary loss
   localparam int PRIMARY_LOSS_TIMEOUT_NS = 20000;

   // width of the shared down/up counters
   localparam int COUNT_WIDTH = 16;

   // reset value of the gate drive and of every status flag except keep-off, which resets to its inverse
   localparam logic DRIVE_RESET = 1'h0;

   // strap value that selects the one-shot variant
   localparam logic VARIANT_ONE_SHOT = 1'h1;

   // convert a time to whole cycles, rounded down, never below one
   function automatic int ns_to_cycles(input int ns);
      int cyc;
      cyc = ns / CLOCK_PERIOD_NS;
      if (cyc < 1) begin
         cyc = 1;
      end
      return cyc;
   endfunction

   // wiring mode picked at primary power-up
   typedef enum logic [1:0] {
      MODE_UNDECIDED,
      MODE_TWO_WIRE,
      MODE_THREE_WIRE
   } isd_mode_type;

   // one-shot pulse sequencer
   typedef enum logic [1:0] {
      SHOT_IDLE,
      SHOT_PULSE,
      SHOT_SPENT
   } isd_shot_type;

endpackage

// ===== isd_uvlo_hyst.sv
// undervoltage lockout flag with separate rising and falling thresholds
`timescale 1ns/10ps

module isd_uvlo_hyst
   import isd_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // comparator results, synchronous to clock
   input  wire logic above_rise,
   input  wire logic above_fall,
   // registered supply state
   output logic      powered_up
);

   logic up_ff;   // supply counted as powered up

   // set at the rising threshold, clear only below the falling one;
   // between the two the last state holds, which gives the hysteresis
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         up_ff <= DRIVE_RESET;
      end else if (above_rise) begin
         up_ff <= 1'h1;
      end else if (!above_fall) begin
         up_ff <= 1'h0;
      end
   end

   assign powered_up = up_ff;

   // reaching the rising threshold powers the supply up next cycle
   AST_UVLO_RISE: assert property (@(posedge clock) disable iff (!arst_n)
      above_rise |=> up_ff)
      else $error("supply not up after rising threshold");

   // inside the hysteresis band the state must not change
   AST_UVLO_BAND: assert property (@(posedge clock) disable iff (!arst_n)
      (!above_rise && above_fall) |=> (up_ff == $past(up_ff)))
      else $error("supply state moved inside hysteresis band");

   // dropping below the falling threshold powers the supply down
   AST_UVLO_FALL: assert property (@(posedge clock) disable iff (!arst_n)
      (!above_rise && !above_fall) |=> !up_ff)
      else $error("supply still up below falling threshold");

endmodule

// ===== isd_switch_ctrl.sv
// gate drive mode control of an isolated switch driver
`timescale 1ns/10ps

module isd_switch_ctrl
   import isd_pkg::*;
#(
   parameter int PULSE_CYCLES   = ns_to_cycles(ONE_SHOT_WIDTH_NS),
   parameter int TIMEOUT_CYCLES = ns_to_cycles(PRIMARY_LOSS_TIMEOUT_NS)
)
(
   // clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // primary supply comparators
   input  wire logic primary_above_rise,
   input  wire logic primary_above_fall,
   // secondary high rail comparators
   input  wire logic secondary_above_rise,
   input  wire logic secondary_above_fall,
   // control and status inputs
   input  wire logic enable_in,
   input  wire logic over_temp,
   input  wire logic one_shot_variant,
   // gate drive and status outputs
   output logic      gate_drive_out,
   output logic      keep_off_active,
   output logic      power_transfer_en,
   output logic      two_wire_mode,
   output logic      three_wire_mode
);

   // refuse counts that the counters cannot hold
   if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << COUNT_WIDTH)) begin : g_chk_pulse
      $error("one-shot pulse count out of range");
   end
   if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << COUNT_WIDTH)) begin : g_chk_tmo
      $error("primary loss timeout count out of range");
   end

   localparam logic [COUNT_WIDTH-1:0] PULSE_LAST = COUNT_WIDTH'(PULSE_CYCLES - 1);
   localparam logic [COUNT_WIDTH-1:0] TMO_LAST   = COUNT_WIDTH'(TIMEOUT_CYCLES - 1);
   localparam logic [COUNT_WIDTH-1:0] CNT_ZERO   = '0;
   localparam logic [COUNT_WIDTH-1:0] CNT_ONE    = COUNT_WIDTH'(1);

   logic                   primary_up;      // primary supply powered up
   logic                   secondary_up;    // secondary high rail powered up
   logic                   variant_ff;      // strap: one-shot variant
   logic                   strap_taken_ff;  // strap captured once after reset
   logic                   enable_d_ff;     // enable one cycle ago, for edges
   isd_mode_type           mode_ff;         // wiring mode
   isd_mode_type           nxt_mode;
   isd_shot_type           shot_ff;         // one-shot sequencer
   isd_shot_type           nxt_shot;
   logic [COUNT_WIDTH-1:0] shot_cnt_ff;     // pulse cycles left
   logic [COUNT_WIDTH-1:0] nxt_shot_cnt;
   logic [COUNT_WIDTH-1:0] hold_cnt_ff;     // hold-over cycles spent
   logic                   timed_out_ff;    // hold-over expired
   logic                   gate_ff;         // registered gate drive
   logic                   nxt_gate;
   logic                   keep_off_ff;
   logic                   xfer_ff;
   logic                   two_ff;
   logic                   three_ff;
   logic                   run_ok;          // both supplies up, cool, mode known
   logic                   shot_mode;       // one-shot behaviour in effect
   logic                   enable_rise;

   // supply detectors, each with its own hysteresis
   isd_uvlo_hyst u_primary_uvlo (
      .clock      (clock),
      .arst_n     (arst_n),
      .above_rise (primary_above_rise),
      .above_fall (primary_above_fall),
      .powered_up (primary_up)
   );

   isd_uvlo_hyst u_secondary_uvlo (
      .clock      (clock),
      .arst_n     (arst_n),
      .above_rise (secondary_above_rise),
      .above_fall (secondary_above_fall),
      .powered_up (secondary_up)
   );

   // variant strap is caught by the clock after release, never by the reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         variant_ff     <= DRIVE_RESET;
         strap_taken_ff <= DRIVE_RESET;
      end else if (!strap_taken_ff) begin
         variant_ff     <= (one_shot_variant == VARIANT_ONE_SHOT);
         strap_taken_ff <= 1'h1;
      end
   end

   // enable history for edge detection
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         enable_d_ff <= DRIVE_RESET;
      end else begin
         enable_d_ff <= enable_in;
      end
   end

   // mode is chosen on the first cycle the primary counts as up and is
   // held until the primary powers down; in two-wire use enable is the
   // supply itself, so it is already high at that moment
   always_comb begin
      nxt_mode = mode_ff;
      if (!primary_up) begin
         nxt_mode = MODE_UNDECIDED;
      end else if (mode_ff == MODE_UNDECIDED) begin
         if (enable_in) begin
            nxt_mode = MODE_TWO_WIRE;
         end else begin
            nxt_mode = MODE_THREE_WIRE;
         end
      end
   end

   // mode register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff <= MODE_UNDECIDED;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   assign run_ok      = primary_up && secondary_up && !over_temp &&
                        (mode_ff != MODE_UNDECIDED);
   assign shot_mode   = variant_ff && (mode_ff == MODE_THREE_WIRE);
   assign enable_rise = enable_in && !enable_d_ff;

   // one-shot sequencer: a rise starts a fixed-length pulse; after it the
   // sequencer waits for enable low, so holding enable high gives one pulse
   always_comb begin
      nxt_shot     = shot_ff;
      nxt_shot_cnt = shot_cnt_ff;
      if (!shot_mode) begin
         nxt_shot     = SHOT_IDLE;
         nxt_shot_cnt = CNT_ZERO;
      end else begin
         unique case (shot_ff)
            SHOT_IDLE: begin
               if (run_ok && enable_rise) begin
                  nxt_shot     = SHOT_PULSE;
                  nxt_shot_cnt = PULSE_LAST;
               end
            end
            SHOT_PULSE: begin
               // a fault cuts the pulse short; re-arming still needs enable low
               if (!run_ok || shot_cnt_ff == CNT_ZERO) begin
                  nxt_shot = SHOT_SPENT;
               end else begin
                  nxt_shot_cnt = shot_cnt_ff - CNT_ONE;
               end
            end
            SHOT_SPENT: begin
               if (!enable_in) begin
                  nxt_shot = SHOT_IDLE;
               end
            end
            default: begin
               nxt_shot = SHOT_IDLE;
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         shot_ff     <= SHOT_IDLE;
         shot_cnt_ff <= CNT_ZERO;
      end else begin
         shot_ff     <= nxt_shot;
         shot_cnt_ff <= nxt_shot_cnt;
      end
   end

   // hold-over timer: runs while the primary is down and the secondary
   // still holds charge; cleared as soon as the primary returns
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hold_cnt_ff  <= CNT_ZERO;
         timed_out_ff <= DRIVE_RESET;
      end else if (primary_up || !secondary_up) begin
         hold_cnt_ff  <= CNT_ZERO;
         timed_out_ff <= 1'h0;
      end else if (!timed_out_ff) begin
         if (hold_cnt_ff == TMO_LAST) begin
            timed_out_ff <= 1'h1;
         end else begin
            hold_cnt_ff <= hold_cnt_ff + CNT_ONE;
         end
      end
   end

   // gate level, highest priority first; during the hold-over the last
   // level is kept since the primary can no longer command a change
   always_comb begin
      if (!secondary_up) begin
         nxt_gate = 1'h0;
      end else if (!primary_up) begin
         nxt_gate = timed_out_ff ? 1'h0 : gate_ff;
      end else if (over_temp) begin
         nxt_gate = 1'h0;
      end else if (mode_ff == MODE_UNDECIDED) begin
         nxt_gate = 1'h0;
      end else if (shot_mode) begin
         nxt_gate = (nxt_shot == SHOT_PULSE);
      end else begin
         nxt_gate = enable_in;
      end
   end

   // output registers; keep-off is applied whenever the gate is held low
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gate_ff     <= DRIVE_RESET;
         keep_off_ff <= ~DRIVE_RESET;
         xfer_ff     <= DRIVE_RESET;
         two_ff      <= DRIVE_RESET;
         three_ff    <= DRIVE_RESET;
      end else begin
         gate_ff     <= nxt_gate;
         keep_off_ff <= !nxt_gate;
         xfer_ff     <= primary_up && !over_temp;
         two_ff      <= (nxt_mode == MODE_TWO_WIRE);
         three_ff    <= (nxt_mode == MODE_THREE_WIRE);
      end
   end

   assign gate_drive_out    = gate_ff;
   assign keep_off_active   = keep_off_ff;
   assign power_transfer_en = xfer_ff;
   assign two_wire_mode     = two_ff;
   assign three_wire_mode   = three_ff;

   // helper: standard enable path in charge this cycle
   logic                   std_ok;
   logic [COUNT_WIDTH-1:0] high_len_ff;   // length of the current one-shot high
   assign std_ok = run_ok && !shot_mode;

   // helper: count cycles the gate stays high under one-shot control
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         high_len_ff <= CNT_ZERO;
      end else if (gate_ff && shot_mode && primary_up) begin
         high_len_ff <= high_len_ff + CNT_ONE;
      end else begin
         high_len_ff <= CNT_ZERO;
      end
   end

   // standard variant follows enable one cycle later, both levels
   AST_FOLLOW_HIGH: assert property (@(posedge clock) disable iff (!arst_n)
      (std_ok && enable_in) |=> gate_drive_out)
      else $error("gate did not follow enable high");

   AST_FOLLOW_LOW: assert property (@(posedge clock) disable iff (!arst_n)
      (std_ok && !enable_in) |=> !gate_drive_out)
      else $error("gate did not follow enable low");

   // a qualified rise gives a pulse that ends within the fixed width
   AST_SHOT_START: assert property (@(posedge clock) disable iff (!arst_n)
      (shot_mode && run_ok && shot_ff == SHOT_IDLE && enable_rise) |=> gate_drive_out)
      else $error("enable rise gave no pulse");

   AST_SHOT_WIDTH: assert property (@(posedge clock) disable iff (!arst_n)
      high_len_ff <= COUNT_WIDTH'(PULSE_CYCLES))
      else $error("one-shot pulse longer than fixed width");

   // no second pulse while enable stays high after the first
   AST_NO_REPULSE: assert property (@(posedge clock) disable iff (!arst_n)
      (shot_ff == SHOT_SPENT && enable_in) |=> (shot_ff != SHOT_PULSE))
      else $error("pulse re-issued without enable low");

   // two-wire mode never runs the one-shot sequencer
   AST_TWO_WIRE_STD: assert property (@(posedge clock) disable iff (!arst_n)
      (mode_ff == MODE_TWO_WIRE) |=> (shot_ff == SHOT_IDLE))
      else $error("one-shot active in two-wire mode");

   // secondary rail down: gate low with keep-off
   AST_SEC_DOWN: assert property (@(posedge clock) disable iff (!arst_n)
      !secondary_up |=> (!gate_drive_out && keep_off_active))
      else $error("gate not held off with secondary down");

   // hold-over expiry forces the gate low
   AST_TIMEOUT: assert property (@(posedge clock) disable iff (!arst_n)
      (!primary_up && secondary_up && hold_cnt_ff == TMO_LAST) |=> ##1 !gate_drive_out)
      else $error("gate not disabled after primary loss timeout");

   // once chosen the mode stays while the primary is up
   AST_MODE_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
      (primary_up && mode_ff != MODE_UNDECIDED) |=> (mode_ff == $past(mode_ff)))
      else $error("mode changed without a primary power cycle");

   // over-temperature: no transfer and gate low
   AST_OVER_TEMP: assert property (@(posedge clock) disable iff (!arst_n)
      (over_temp && primary_up) |=> (!gate_drive_out && !power_transfer_en))
      else $error("over-temperature did not stop the driver");

endmodule

// ===== isd_gate_load.sv
// behavioural model of the external power switch gate driven by the block
`timescale 1ns/10ps

module isd_gate_load
   import isd_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // gate drive seen from the switch side
   input  wire logic       gate_drive_out,
   input  wire logic       keep_off_active,
   // switch state as the load sees it
   output logic            switch_on_ff,
   output logic [7:0]      turn_on_count_ff
);
   logic                   nxt_switch_on;   // gate charged and not clamped

   // keep-off clamps the gate, so it wins over a stray drive level
   assign nxt_switch_on = gate_drive_out & ~keep_off_active;

   // gate charge lags the drive by one cycle, like a real gate capacitance
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         switch_on_ff <= 1'h0;
      end else begin
         switch_on_ff <= nxt_switch_on;
      end
   end

   // count each turn-on so a bench can see how many pulses reached the switch
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         turn_on_count_ff <= 8'h00;
      end else if (nxt_switch_on && !switch_on_ff) begin
         turn_on_count_ff <= turn_on_count_ff + 8'h01;
      end
   end
endmodule

// ===== isd_switch_ctrl_tb.sv
// self-checking bench for the gate drive mode control
`timescale 1ns/10ps

module isd_switch_ctrl_tb
   import isd_pkg::*;
;
   localparam int PW = 4;   // short pulse keeps the run brief
   localparam int TO = 8;   // short hold-over timeout
   // stimulus and observed signals
   logic       clock = 1'h0;
   logic       arst_n = 1'h0;
   logic       p_rise = 1'h0;
   logic       p_fall = 1'h0;
   logic       s_rise = 1'h0;
   logic       s_fall = 1'h0;
   logic       enable_in = 1'h0;
   logic       over_temp = 1'h0;
   logic       variant = 1'h0;
   logic       gate_drive_out;
   logic       keep_off_active;
   logic       power_transfer_en;
   logic       two_wire_mode;
   logic       three_wire_mode;
   logic       switch_on;
   logic [7:0] turns;
   int         err_count = 0;
   int         total_checks = 0;

   // 40 MHz clock
   always #12.5 clock = ~clock;

   isd_switch_ctrl #(.PULSE_CYCLES(PW), .TIMEOUT_CYCLES(TO)) dut_u (
      .clock(clock), .arst_n(arst_n),
      .primary_above_rise(p_rise), .primary_above_fall(p_fall),
      .secondary_above_rise(s_rise), .secondary_above_fall(s_fall),
      .enable_in(enable_in), .over_temp(over_temp), .one_shot_variant(variant),
      .gate_drive_out(gate_drive_out), .keep_off_active(keep_off_active),
      .power_transfer_en(power_transfer_en), .two_wire_mode(two_wire_mode),
      .three_wire_mode(three_wire_mode));

   isd_gate_load load_u (
      .clock(clock), .arst_n(arst_n), .gate_drive_out(gate_drive_out),
      .keep_off_active(keep_off_active), .switch_on_ff(switch_on),
      .turn_on_count_ff(turns));

   // inputs always move 2 ns after the rising edge, clear of sampling
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // reset with all supplies off, then power up; en chooses the wiring mode
   task automatic power_up(input logic v, input logic en);
      arst_n = 1'h0;
      {p_rise, p_fall, s_rise, s_fall, over_temp} = 5'h00;
      enable_in = en;
      variant = v;
      cyc(20);
      arst_n = 1'h1;
      cyc(2);
      {s_rise, s_fall} = 2'h3;
      cyc(1);
      {p_rise, p_fall} = 2'h3;
      cyc(5);
   endtask

   // standard variant follows enable level in three-wire mode
   task automatic t_standard();
      power_up(1'h0, 1'h0);
      check(three_wire_mode, 1'h1);
      check(two_wire_mode, 1'h0);
      check(gate_drive_out, 1'h0);
      enable_in = 1'h1;
      cyc(2);
      check(gate_drive_out, 1'h1);
      check(keep_off_active, 1'h0);
      cyc(30);
      check(gate_drive_out, 1'h1);
      enable_in = 1'h0;
      cyc(2);
      check(gate_drive_out, 1'h0);
      $display("test standard done");
   endtask

   // enable high before primary up gives two-wire, where no one-shot exists
   task automatic t_two_wire();
      power_up(1'h1, 1'h1);
      check(two_wire_mode, 1'h1);
      check(three_wire_mode, 1'h0);
      cyc(20);
      check(gate_drive_out, 1'h1);
      enable_in = 1'h0;
      cyc(3);
      check(gate_drive_out, 1'h0);
      check(two_wire_mode, 1'h1);
      $display("test two_wire done");
   endtask

   // one-shot variant: fixed width pulse per rise, rearm only after low
   task automatic t_one_shot();
      int hi;
      logic [7:0] t0;
      power_up(1'h1, 1'h0);
      check(three_wire_mode, 1'h1);
      t0 = turns;
      hi = 0;
      enable_in = 1'h1;
      repeat (30) begin
         cyc(1);
         if (gate_drive_out === 1'h1) hi++;
      end
      check(8'(hi), 8'(PW));
      check(turns, t0 + 8'h01);
      check(gate_drive_out, 1'h0);
      enable_in = 1'h0;
      cyc(3);
      enable_in = 1'h1;
      hi = 0;
      repeat (12) begin
         cyc(1);
         if (gate_drive_out === 1'h1) hi++;
      end
      check(8'(hi), 8'(PW));
      check(turns, t0 + 8'h02);
      $display("test one_shot done");
   endtask

   // secondary rail loss forces low; rail needs its rising level to return
   task automatic t_secondary();
      power_up(1'h0, 1'h1);
      power_up(1'h0, 1'h0);
      enable_in = 1'h1;
      cyc(3);
      s_rise = 1'h0;
      cyc(6);
      check(gate_drive_out, 1'h1);
      s_fall = 1'h0;
      cyc(3);
      check(gate_drive_out, 1'h0);
      check(keep_off_active, 1'h1);
      s_fall = 1'h1;
      cyc(6);
      check(gate_drive_out, 1'h0);
      s_rise = 1'h1;
      cyc(3);
      check(gate_drive_out, 1'h1);
      $display("test secondary done");
   endtask

   // primary hysteresis, then loss: gate held until timeout, then low
   task automatic t_primary();
      power_up(1'h0, 1'h0);
      enable_in = 1'h1;
      cyc(3);
      p_rise = 1'h0;
      cyc(10);
      check(gate_drive_out, 1'h1);
      check(three_wire_mode, 1'h1);
      p_fall = 1'h0;
      cyc(5);
      check(gate_drive_out, 1'h1);
      // gate drops two cycles after the hold count reaches its last value
      cyc(TO - 4);
      check(gate_drive_out, 1'h1);
      cyc(1);
      check(gate_drive_out, 1'h0);
      check(keep_off_active, 1'h1);
      check(three_wire_mode, 1'h0);
      $display("test primary done");
   endtask

   // over-temperature stops transfer and forces the gate low while it lasts
   task automatic t_over_temp();
      power_up(1'h0, 1'h0);
      check(power_transfer_en, 1'h1);
      enable_in = 1'h1;
      cyc(3);
      over_temp = 1'h1;
      cyc(2);
      check(gate_drive_out, 1'h0);
      check(power_transfer_en, 1'h0);
      check(switch_on, 1'h0);
      over_temp = 1'h0;
      cyc(3);
      check(power_transfer_en, 1'h1);
      check(gate_drive_out, 1'h1);
      $display("test over_temp done");
   endtask

   // main sequence
   initial begin
      t_standard();
      t_two_wire();
      t_one_shot();
      t_secondary();
      t_primary();
      t_over_temp();
      end_sim();
   end

   // watchdog: the tests need well under 1000 cycles
   initial begin
      #(CLOCK_PERIOD_NS * 5000);
      err_count++;
      end_sim();
   end
endmodule
